// ### design/sisa_agent.sv
/*
 serial interrupt slave agent: drives interrupt levels into their slots
 on the shared serial interrupt wire, decodes stop pulse width into the
 quiet or continuous mode and requests start frames in quiet mode.
 assumes: the wire clock is a free clock port of its own, the pin pad
 resolves out/oe with a pull-up, interrupt lines are active low levels.
*/
// Contract
// - quiet request is one low clock, then release
// - never request while a cycle is active
// - quiet mode: line change requests a start
// - continuous mode: device never requests a cycle
// - mode changes only at stop; reset continuous
// - stop two low quiet, three low continuous
// - count three-clock frames from start rising edge
// - sample phase: drive low only if level low
// - recovery drives high after own low; turn releases
// - report levels whoever started the cycle
// - frame n sampled 3n-1 clocks after start
// - frame three carries line two or management
// - frame fourteen carries line thirteen
// - management bits six serial, seven pin
// - new start two clocks after stop edge
// - level change reaches host within 96 clocks
// - drive and sample on wire clock rising edge
// - reset releases wire and forces continuous mode
module sisa_agent
   import sisa_pkg::*;
#(
   parameter logic [NUM_LINES-1:0] SERVED_MASK = SERVED_DEFAULT
) (
   input wire logic MCLK_I,                          // system clock
   input wire logic RST_I,                           // bus reset drive, sync, active high
   input wire logic SERIAL_IRQ_PIN_CLK_I,                      // serial interrupt wire clock
   input wire logic SERIAL_IRQ_PIN_I,                // wire level seen at pin
   output logic SERIAL_IRQ_PIN_O,                    // wire drive value
   output logic SERIAL_IRQ_PIN_OE_O,                 // wire drive enable
   input wire logic [NUM_LINES-1:0] IRQ_LEVEL_N_I,   // interrupt lines, active low
   input wire logic SYSTEM_MGMT_INTERRUPT_N_I,       // management interrupt, active low
   input wire logic [7:0] MGMT_IRQ_ENABLE_REG2_I,    // management enable register 2
   output logic SYSTEM_MGMT_INTERRUPT_N_O,           // dedicated management pin
   output logic QUIET_MODE_O                         // current mode, high quiet
);

   // ==========================================================
   // system side: slot levels and management pin
   // ==========================================================
   logic [NUM_LINES-1:0] slot_lvl_ff;
   logic [NUM_LINES-1:0] nxt_slot_lvl;
   logic mgmt_pin_ff;

   // ==========================================================
   // pin inputs: two flip-flops before any logic reads them
   // ==========================================================
   logic [NUM_LINES-1:0] irq_lvl_s;
   logic mgmt_n_s;

   // lines are independent levels, so a bit-wise crossing is enough
   sisa_sync #(.WIDTH(NUM_LINES), .INIT(LINES_IDLE)) u_irq_sync (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .d_i(IRQ_LEVEL_N_I),
      .q_o(irq_lvl_s)
   );

   sisa_sync #(.WIDTH(1), .INIT(1'b1)) u_mgmt_sync (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .d_i(SYSTEM_MGMT_INTERRUPT_N_I),
      .q_o(mgmt_n_s)
   );

   always_comb begin
      nxt_slot_lvl = irq_lvl_s;
      // frame three shared by line two and management interrupt
      nxt_slot_lvl[MGMT_LINE] = irq_lvl_s[MGMT_LINE]
         & (mgmt_n_s | ~MGMT_IRQ_ENABLE_REG2_I[MGMT_SERIAL_BIT]);
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         slot_lvl_ff <= LINES_IDLE;
      end else begin
         slot_lvl_ff <= nxt_slot_lvl;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         mgmt_pin_ff <= 1'b1;
      end else begin
         mgmt_pin_ff <= ~(MGMT_IRQ_ENABLE_REG2_I[MGMT_PIN_BIT] & ~mgmt_n_s);
      end
   end

   assign SYSTEM_MGMT_INTERRUPT_N_O = mgmt_pin_ff;

   // ==========================================================
   // crossings
   // ==========================================================
   logic link_rst;
   logic [NUM_LINES-1:0] link_lvl;
   logic wire_s;
   logic quiet_ff;

   sisa_sync #(.WIDTH(1), .INIT(1'b1)) u_rst_sync (
      .clk_i(SERIAL_IRQ_PIN_CLK_I),
      .rst_i(1'b0),
      .d_i(RST_I),
      .q_o(link_rst)
   );

   sisa_sync #(.WIDTH(NUM_LINES), .INIT(LINES_IDLE)) u_lvl_sync (
      .clk_i(SERIAL_IRQ_PIN_CLK_I),
      .rst_i(link_rst),
      .d_i(slot_lvl_ff),
      .q_o(link_lvl)
   );

   sisa_sync #(.WIDTH(1), .INIT(1'b1)) u_wire_sync (
      .clk_i(SERIAL_IRQ_PIN_CLK_I),
      .rst_i(link_rst),
      .d_i(SERIAL_IRQ_PIN_I),
      .q_o(wire_s)
   );

   sisa_sync #(.WIDTH(1), .INIT(1'b0)) u_mode_sync (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .d_i(quiet_ff),
      .q_o(QUIET_MODE_O)
   );

   // ==========================================================
   // link side: pulse width measurement
   // ==========================================================
   logic wire_d_ff;
   logic [RUN_W-1:0] low_run_ff;
   logic rise;
   logic start_seen;
   logic stop_quiet;
   logic stop_cont;

   always_ff @(posedge SERIAL_IRQ_PIN_CLK_I) begin
      if (link_rst) begin
         wire_d_ff <= 1'b1;
      end else begin
         wire_d_ff <= wire_s;
      end
   end

   // low_run_ff holds the length of the finished low pulse at the rise
   always_ff @(posedge SERIAL_IRQ_PIN_CLK_I) begin
      if (link_rst) begin
         low_run_ff <= '0;
      end else if (!wire_s) begin
         if (low_run_ff != RUN_MAX) begin
            low_run_ff <= low_run_ff + 4'h1;
         end
      end else begin
         low_run_ff <= '0;
      end
   end

   assign rise = wire_s & ~wire_d_ff;
   assign start_seen = rise && (low_run_ff >= START_MIN_LOW);
   assign stop_quiet = rise && (low_run_ff == STOP_QUIET_LOW);
   assign stop_cont = rise && (low_run_ff == STOP_CONT_LOW);

   // ==========================================================
   // link side: cycle state, frame and phase
   // ==========================================================
   sisa_link_state_t state_ff;
   sisa_link_state_t nxt_state;
   sisa_phase_t phase_ff;
   sisa_phase_t nxt_phase;
   logic [FRM_W-1:0] frame_ff;
   logic [FRM_W-1:0] nxt_frame;

   always_comb begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      nxt_frame = frame_ff;
      case (state_ff)
         LS_IDLE: begin
            if (start_seen) begin
               // detect cycle is the start frame turn-around clock of frame 1
               nxt_state = LS_ACTIVE;
               nxt_frame = FRAME_AT_DETECT;
               nxt_phase = PH_TURN;
            end
         end
         LS_ACTIVE: begin
            if (start_seen) begin
               nxt_frame = FRAME_AT_DETECT;
               nxt_phase = PH_TURN;
            end else if (stop_quiet || stop_cont) begin
               nxt_state = LS_IDLE;
               nxt_phase = PH_SAMPLE;
               nxt_frame = '0;
            end else begin
               case (phase_ff)
                  PH_SAMPLE: begin
                     nxt_phase = PH_RECOVER;
                  end
                  PH_RECOVER: begin
                     nxt_phase = PH_TURN;
                  end
                  PH_TURN: begin
                     nxt_phase = PH_SAMPLE;
                     if (frame_ff != FRAME_MAX) begin
                        nxt_frame = frame_ff + 5'h01;
                     end
                  end
                  default: begin
                     nxt_phase = PH_SAMPLE;
                  end
               endcase
            end
         end
         default: begin
            nxt_state = LS_IDLE;
            nxt_phase = PH_SAMPLE;
            nxt_frame = '0;
         end
      endcase
   end

   always_ff @(posedge SERIAL_IRQ_PIN_CLK_I) begin
      if (link_rst) begin
         state_ff <= LS_IDLE;
         phase_ff <= PH_SAMPLE;
         frame_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         frame_ff <= nxt_frame;
      end
   end

   // mode follows only the stop pulse width
   always_ff @(posedge SERIAL_IRQ_PIN_CLK_I) begin
      if (link_rst) begin
         quiet_ff <= 1'b0;
      end else if (state_ff == LS_ACTIVE && stop_quiet) begin
         quiet_ff <= 1'b1;
      end else if (state_ff == LS_ACTIVE && stop_cont) begin
         quiet_ff <= 1'b0;
      end
   end

   // ==========================================================
   // link side: slot drive and start request
   // ==========================================================
   logic [3:0] slot_idx;
   logic in_slot;
   logic slot_low;
   logic [NUM_LINES-1:0] sent_ff;
   logic drove_ff;
   logic req_wait_ff;
   logic change_pending;
   logic do_request;
   sisa_drive_t drive_ff;
   sisa_drive_t nxt_drive;

   assign slot_idx = 4'(nxt_frame[3:0] - 4'h1);
   assign in_slot = (nxt_state == LS_ACTIVE) && (nxt_phase == PH_SAMPLE)
      && (nxt_frame >= FIRST_IRQ_FRAME) && (nxt_frame <= LAST_IRQ_FRAME)
      && SERVED_MASK[slot_idx];
   assign slot_low = in_slot && !link_lvl[slot_idx];

   // a change is pending until its level has gone out in its slot
   assign change_pending = |((link_lvl ^ sent_ff) & SERVED_MASK);
   assign do_request = quiet_ff && (state_ff == LS_IDLE) && (nxt_state == LS_IDLE)
      && change_pending && !req_wait_ff && wire_s && !rise;

   always_comb begin
      nxt_drive = DRIVE_OFF;
      if (slot_low) begin
         nxt_drive = DRIVE_LOW;
      end else if (nxt_state == LS_ACTIVE && nxt_phase == PH_RECOVER && drove_ff) begin
         nxt_drive = DRIVE_HIGH;
      end else if (do_request) begin
         nxt_drive = DRIVE_LOW;
      end
   end

   always_ff @(posedge SERIAL_IRQ_PIN_CLK_I) begin
      if (link_rst) begin
         drive_ff <= DRIVE_OFF;
      end else begin
         drive_ff <= nxt_drive;
      end
   end

   always_ff @(posedge SERIAL_IRQ_PIN_CLK_I) begin
      if (link_rst) begin
         drove_ff <= 1'b0;
      end else begin
         drove_ff <= slot_low;
      end
   end

   generate
      for (genvar i = 0; i < NUM_LINES; i++) begin : g_sent
         always_ff @(posedge SERIAL_IRQ_PIN_CLK_I) begin
            if (link_rst) begin
               sent_ff[i] <= LINES_IDLE[i];
            end else if (in_slot && slot_idx == 4'(i)) begin
               sent_ff[i] <= link_lvl[i];
            end
         end
      end
   endgenerate

   // one request per pulse; any finished pulse allows a retry
   always_ff @(posedge SERIAL_IRQ_PIN_CLK_I) begin
      if (link_rst) begin
         req_wait_ff <= 1'b0;
      end else if (do_request) begin
         req_wait_ff <= 1'b1;
      end else if (rise) begin
         req_wait_ff <= 1'b0;
      end
   end

   assign SERIAL_IRQ_PIN_O = drive_ff.out;
   assign SERIAL_IRQ_PIN_OE_O = drive_ff.oe;

endmodule

// ### design/sisa_pkg.sv
/*
 package for the serial interrupt slave agent: slot numbering, pulse
 widths, reset values, phase and link state codes, pin drive carrier.
 assumes nothing of its surroundings.
*/
package sisa_pkg;

   // ==========================================================
   // slot and pulse constants
   // ==========================================================
   localparam int NUM_LINES = 16;
   localparam int FRM_W = 5;
   localparam int RUN_W = 4;
   localparam logic [FRM_W-1:0] FRAME_AT_DETECT = 5'h01;
   localparam logic [FRM_W-1:0] FIRST_IRQ_FRAME = 5'h02;
   localparam logic [FRM_W-1:0] LAST_IRQ_FRAME = 5'h10;
   localparam logic [FRM_W-1:0] FRAME_MAX = 5'h1F;
   localparam logic [RUN_W-1:0] START_MIN_LOW = 4'h4;
   localparam logic [RUN_W-1:0] STOP_QUIET_LOW = 4'h2;
   localparam logic [RUN_W-1:0] STOP_CONT_LOW = 4'h3;
   localparam logic [RUN_W-1:0] RUN_MAX = 4'hF;
   localparam int MGMT_LINE = 2;
   localparam int MGMT_SERIAL_BIT = 6;
   localparam int MGMT_PIN_BIT = 7;

   // ==========================================================
   // reset values and default served mask
   // ==========================================================
   localparam logic [NUM_LINES-1:0] LINES_IDLE = 16'hFFFF;
   localparam logic [NUM_LINES-1:0] SERVED_DEFAULT = 16'hFFFE;

   // ==========================================================
   // types
   // ==========================================================
   typedef enum logic [1:0] {
      PH_SAMPLE = 2'b00,
      PH_RECOVER = 2'b01,
      PH_TURN = 2'b10
   } sisa_phase_t;

   typedef enum logic [1:0] {
      LS_IDLE = 2'b00,
      LS_ACTIVE = 2'b01
   } sisa_link_state_t;

   typedef struct packed {
      logic out;
      logic oe;
   } sisa_drive_t;

   localparam sisa_drive_t DRIVE_OFF = '{out: 1'b0, oe: 1'b0};
   localparam sisa_drive_t DRIVE_LOW = '{out: 1'b0, oe: 1'b1};
   localparam sisa_drive_t DRIVE_HIGH = '{out: 1'b1, oe: 1'b1};

endpackage

// ### design/sisa_sync.sv
/*
 two flip-flop level synchroniser, any width, synchronous reset to a
 constant. assumes each bit is an independent level.
*/
module sisa_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk_i,              // destination clock
   input wire logic rst_i,              // synchronous reset, active high
   input wire logic [WIDTH-1:0] d_i,    // asynchronous levels
   output logic [WIDTH-1:0] q_o         // synchronised levels
);

   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= INIT;
         q_o <= INIT;
      end else begin
         meta_ff <= d_i;
         q_o <= meta_ff;
      end
   end

endmodule

// ### dv/sisa_agent_sva.sv
/*
 checker for the serial interrupt agent ports.
 assumes a pulled-up wire and only the host making 2 or 3 low pulses.
*/
module sisa_agent_chk (
   input wire logic MCLK_I,                       // system clock
   input wire logic RST_I,                        // reset
   input wire logic SERIAL_IRQ_PIN_CLK_I,                   // wire clock
   input wire logic SERIAL_IRQ_PIN_I,             // wire level
   input wire logic SERIAL_IRQ_PIN_O,             // drive value
   input wire logic SERIAL_IRQ_PIN_OE_O,          // drive enable
   input wire logic SYSTEM_MGMT_INTERRUPT_N_I,    // mgmt input
   input wire logic [7:0] MGMT_IRQ_ENABLE_REG2_I, // mgmt enables
   input wire logic SYSTEM_MGMT_INTERRUPT_N_O,    // mgmt pin
   input wire logic QUIET_MODE_O                  // mode
);
   wire logic p = SERIAL_IRQ_PIN_I;
   wire logic o = SERIAL_IRQ_PIN_O;
   wire logic oe = SERIAL_IRQ_PIN_OE_O;
   logic [3:0] lo_ff;
   logic act_ff;
   // ==========================================
   // cycle tracking from the wire
   // ==========================================
   always_ff @(posedge SERIAL_IRQ_PIN_CLK_I) begin
      if (RST_I) begin
         lo_ff <= 4'h0;
         act_ff <= 1'b0;
      end else begin
         lo_ff <= p ? 4'h0 : (lo_ff == 4'hF ? lo_ff : lo_ff + 4'h1);
         if (p && lo_ff >= 4'h4) act_ff <= 1'b1;
         else if (p && (lo_ff == 4'h2 || lo_ff == 4'h3)) act_ff <= 1'b0;
      end
   end
   // ==========================================
   // assertions
   // ==========================================
   a_rec_high: assert property (@(posedge SERIAL_IRQ_PIN_CLK_I) disable iff (RST_I)
      act_ff && oe && !o |=> oe && o) else $error("recovery high missing");
   a_turn_release: assert property (@(posedge SERIAL_IRQ_PIN_CLK_I) disable iff (RST_I)
      oe && o |=> !oe) else $error("turn-around not released");
   a_req_one: assert property (@(posedge SERIAL_IRQ_PIN_CLK_I) disable iff (RST_I)
      !act_ff && $rose(oe) |-> !o ##1 !oe) else $error("request not one low clock");
   a_cont_silent: assert property (@(posedge SERIAL_IRQ_PIN_CLK_I) disable iff (RST_I)
      !act_ff && !QUIET_MODE_O |-> !oe) else $error("idle drive in continuous mode");
   a_reset_release: assert property (@(posedge SERIAL_IRQ_PIN_CLK_I)
      RST_I [*3] |=> !oe) else $error("wire driven in reset");
   a_mgmt_pin: assert property (@(posedge MCLK_I) disable iff (RST_I)
      1'b1 |=> SYSTEM_MGMT_INTERRUPT_N_O == ~($past(MGMT_IRQ_ENABLE_REG2_I[7]) & ~$past(SYSTEM_MGMT_INTERRUPT_N_I, 3)))
      else $error("mgmt pin wrong");
   a_quiet_decode: assert property (@(posedge SERIAL_IRQ_PIN_CLK_I) disable iff (RST_I)
      p ##1 !p [*2] ##1 p |-> ##8 QUIET_MODE_O) else $error("quiet stop not decoded");
   a_cont_decode: assert property (@(posedge SERIAL_IRQ_PIN_CLK_I) disable iff (RST_I)
      p ##1 !p [*3] ##1 p |-> ##8 !QUIET_MODE_O) else $error("continuous stop not decoded");
   c_request: cover property (@(posedge SERIAL_IRQ_PIN_CLK_I) !act_ff && $rose(oe));
   c_cycle: cover property (@(posedge SERIAL_IRQ_PIN_CLK_I) $rose(act_ff));
   c_quiet: cover property (@(posedge MCLK_I) $rose(QUIET_MODE_O));
endmodule

bind sisa_agent sisa_agent_chk i_chk (.MCLK_I(MCLK_I), .RST_I(RST_I), .SERIAL_IRQ_PIN_CLK_I(SERIAL_IRQ_PIN_CLK_I),
   .SERIAL_IRQ_PIN_I(SERIAL_IRQ_PIN_I), .SERIAL_IRQ_PIN_O(SERIAL_IRQ_PIN_O),
   .SERIAL_IRQ_PIN_OE_O(SERIAL_IRQ_PIN_OE_O), .SYSTEM_MGMT_INTERRUPT_N_I(SYSTEM_MGMT_INTERRUPT_N_I),
   .MGMT_IRQ_ENABLE_REG2_I(MGMT_IRQ_ENABLE_REG2_I), .SYSTEM_MGMT_INTERRUPT_N_O(SYSTEM_MGMT_INTERRUPT_N_O),
   .QUIET_MODE_O(QUIET_MODE_O));

// ### dv/sisa_host_model.sv
/*
 host side model of the serial interrupt wire: start pulse, frame
 sampling, stop pulse. assumes the bench resolves the wire with a pull-up.
*/
module sisa_host_model (
   input wire logic clk_i, // wire clock
   input wire logic pin_i, // resolved wire
   output logic o_o,       // drive value
   output logic oe_o       // drive enable
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_o = 1'b0;
      oe_o = 1'b0;
   end
   // ==========================================
   // one whole cycle, driven on falling edges
   // ==========================================
   task automatic run_cycle(input int w, input int sw, output logic [15:0] got);
      int c;
      @(negedge clk_i);
      oe_o = 1'b1;
      o_o = 1'b0;
      repeat (w) @(negedge clk_i);
      o_o = 1'b1;
      for (c = 2; c < 53; c++) begin
         @(negedge clk_i);
         if (c % 3 == 2 && c < 48) got[(c - 2) / 3] = pin_i;
         oe_o = 1'b0;
         o_o = 1'b0;
      end
      oe_o = 1'b1;
      repeat (sw) @(negedge clk_i);
      o_o = 1'b1;
      @(negedge clk_i);
      oe_o = 1'b0;
      o_o = 1'b0;
   endtask
endmodule

// ### dv/tb_sisa_agent.sv
/*
 bench for the serial interrupt agent: random levels, host cycles.
 assumes the host model and the checker are compiled before it.
*/
module tb_sisa_agent;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic sclk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] lvl_n = 16'hFFFF;
   logic mg_n = 1'b1;
   logic [7:0] reg2 = 8'h00;
   logic d_o, d_oe, h_o, h_oe, mg_o, quiet, seen, qm;
   wire logic pin = (d_oe ? d_o : 1'b1) & (h_oe ? h_o : 1'b1);
   int failures = 0;
   int checks_done = 0;
   int i, w, sw;
   logic [31:0] seed = 32'h00DA;
   logic [15:0] lv, e, prev, got;
   always #5 mclk = ~mclk;
   always #7.5 sclk = ~sclk;
   sisa_agent i_dut (.MCLK_I(mclk), .RST_I(rst), .SERIAL_IRQ_PIN_CLK_I(sclk), .SERIAL_IRQ_PIN_I(pin),
      .SERIAL_IRQ_PIN_O(d_o), .SERIAL_IRQ_PIN_OE_O(d_oe), .IRQ_LEVEL_N_I(lvl_n),
      .SYSTEM_MGMT_INTERRUPT_N_I(mg_n), .MGMT_IRQ_ENABLE_REG2_I(reg2),
      .SYSTEM_MGMT_INTERRUPT_N_O(mg_o), .QUIET_MODE_O(quiet));
   sisa_host_model i_host (.clk_i(sclk), .pin_i(pin), .o_o(h_o), .oe_o(h_oe));
   // ==========================================
   // helpers
   // ==========================================
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [15:0] exp_f(input logic [15:0] l, input logic m, input logic [7:0] r);
      exp_f = l | 16'h0001;
      exp_f[2] = l[2] & (m | ~r[6]);
   endfunction
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] gt);
      checks_done++;
      if (gt !== ex) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, ex, gt);
      end
   endtask
   task automatic watch(input int n, output logic lo);
      lo = 1'b0;
      repeat (n) begin
         @(negedge sclk);
         if (pin === 1'b0) lo = 1'b1;
      end
   endtask
   task report_and_stop;
      if (failures == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      report_and_stop;
   end
   // ==========================================
   // main sequence
   // ==========================================
   initial begin
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      repeat (10) @(negedge mclk);
      chk("quiet", 16'h0000, {15'h0000, quiet});
      chk("oe", 16'h0000, {15'h0000, d_oe});
      qm = 1'b0;
      prev = 16'h0000;
      for (i = 0; i < 14; i++) begin
         seed = xs(seed);
         lv = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : seed[15:0];
         @(negedge mclk);
         lvl_n = lv;
         mg_n = seed[16];
         reg2 = seed[31:24];
         e = exp_f(lv, seed[16], seed[31:24]);
         if (qm || !seed[20]) begin
            watch(30, seen);
            chk("request", {15'h0000, qm && e != prev}, {15'h0000, seen});
         end
         repeat (4) @(negedge mclk);
         chk("mgmt_pin", {15'h0000, ~(reg2[7] & ~mg_n)}, {15'h0000, mg_o});
         w = (i == 0) ? 8 : (i == 1) ? 4 : 4 + seed[10:8] % 5;
         sw = (i == 0 || seed[11]) ? 2 : 3;
         i_host.run_cycle(w, sw, got);
         chk("frames", e, got);
         prev = e;
         qm = (sw == 2);
         repeat (12) @(negedge mclk);
         chk("quiet", {15'h0000, qm}, {15'h0000, quiet});
      end
      report_and_stop;
   end
endmodule
